/* File: gpc_defines.svh */
`ifndef GPC_DEFINES_SVH
`define GPC_DEFINES_SVH

// Register byte addresses in the special-function space
`define GPC_A_DATA0     8'h80
`define GPC_A_DATA1     8'h88
`define GPC_A_DATA2     8'h90
`define GPC_A_DATA3     8'h98
`define GPC_A_DIR0      8'h89
`define GPC_A_DIR1      8'h91
`define GPC_A_DIR2      8'h99
`define GPC_A_DIR3      8'hA1
`define GPC_A_OD0       8'hB1
`define GPC_A_OD1       8'hB9
`define GPC_A_OD2       8'hC1
`define GPC_A_OD3       8'hC9
`define GPC_A_PU0       8'hD1
`define GPC_A_PU1       8'hD9
`define GPC_A_PU2       8'hE1
`define GPC_A_PU3       8'hE9
`define GPC_A_DB0       8'hE2
`define GPC_A_DB1       8'hE3
`define GPC_A_DB2       8'hE4
`define GPC_A_DB3       8'hE5
`define GPC_A_DB_SEL    8'hDA
`define GPC_A_SINK_SEL  8'hDB
`define GPC_A_AIN_LO    8'hDC
`define GPC_A_AIN_HI    8'hDD

// Reset values and implemented-bit masks
`define GPC_REG_RST     8'h00
`define GPC_PORT0_OD_RST 8'h04
`define GPC_PORT2_MASK  8'h3F
`define GPC_DB_SEL_MASK 8'h0F
`define GPC_AIN_HI_MASK 8'h7F
`define GPC_PORT2_PINS  6

// Fields of the debounce length selector
`define GPC_PDB_LSB     0
`define GPC_RDB_LSB     2

// Timing: the filters count 1 us ticks
`define GPC_CLK_NS      10
`define GPC_TICK_NS     1000
`define GPC_TICK_CYC    (`GPC_TICK_NS / `GPC_CLK_NS)
`define GPC_PDB_BASE_US 1
`define GPC_RDB_BASE_US 8

`endif

/* File: gpc_pkg.sv */
package gpc_pkg;

  typedef logic [3:0][7:0] gpc_port_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gpc_sfr_t;

  typedef struct packed {
    gpc_port_t out;
    gpc_port_t oe_n;
    gpc_port_t pu;
    gpc_port_t analog_input_channel;
  } gpc_pads_t;

  typedef struct packed {
    logic [6:0] cnt;
    logic       q;
  } gpc_db_st_t;

  typedef struct packed {
    gpc_port_t  data;
    gpc_port_t  dir;
    gpc_port_t  pu;
    gpc_port_t  od;
    gpc_port_t  db;
    logic [7:0] db_sel;
    logic [7:0] sink_sel;
    logic [7:0] ain_lo;
    logic [7:0] ain_hi;
    logic [6:0] div;
    logic       tick;
    logic [7:0] rdata;
    gpc_pads_t  pads;
    logic [7:0] sink_hi;
  } gpc_st_t;

endpackage : gpc_pkg

/* File: gpc_debounce.sv */
`timescale 1ns/1ns
module gpc_debounce #(
  parameter logic RST_Q = 1'b0
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Timebase and length in ticks
  input  wire logic       tick,
  input  wire logic [6:0] len,
  // Raw and filtered level
  input  wire logic       d,
  output      logic       q
);
  import gpc_pkg::*;

  gpc_db_st_t st_r;
  gpc_db_st_t st_nxt;

  // A mismatch must survive len+1 ticks, so the level is stable for at
  // least len microseconds whatever the tick phase at its start
  always_comb begin
    st_nxt = st_r;
    if (d == st_r.q) begin
      st_nxt.cnt = '0;
    end else if (tick) begin
      if (st_r.cnt >= len) begin
        st_nxt.q   = d;
        st_nxt.cnt = '0;
      end else begin
        st_nxt.cnt = st_r.cnt + 7'd1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '{cnt: 7'd0, q: RST_Q};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.q;

endmodule : gpc_debounce

/* File: gpc_port_cfg.sv */
`timescale 1ns/1ns
`include "gpc_defines.svh"
module gpc_port_cfg #(
  parameter int TICK_CYC = `GPC_TICK_CYC
) (
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // Special-function register access
  input  wire gpc_pkg::gpc_sfr_t   sfr,
  output      logic [7:0]          sfr_rdata,
  // Pads
  input  wire gpc_pkg::gpc_port_t  pin_in,
  output      gpc_pkg::gpc_pads_t  pads,
  output      logic [7:0]          sink_hi,
  // External reset pin and its filtered level
  input  wire logic                ext_rst_n_in,
  output      logic                ext_rst_n_db
);
  import gpc_pkg::*;

  localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

  gpc_st_t   st_r;
  gpc_st_t   st_nxt;
  gpc_port_t pin_db;
  gpc_port_t pin_sel;
  gpc_port_t dig_in;
  gpc_port_t ain_map;
  gpc_port_t port_rd;
  logic [6:0] pdb_len;
  logic [6:0] rdb_len;
  logic [7:0] rv;

  // Filter lengths in 1 us ticks
  assign pdb_len = 7'(`GPC_PDB_BASE_US << st_r.db_sel[`GPC_PDB_LSB +: 2]);
  assign rdb_len = 7'(`GPC_RDB_BASE_US << st_r.db_sel[`GPC_RDB_LSB +: 2]);

  // Pin filters; port 2 pins 7:6 do not exist
  for (genvar p = 0; p < 4; p++) begin : g_port
    for (genvar b = 0; b < 8; b++) begin : g_pin
      if (p != 2 || b < `GPC_PORT2_PINS) begin : g_on
        gpc_debounce #(
          .RST_Q (1'b0)
        ) u_db (
          .mclk (mclk),
          .nrst (nrst),
          .tick (st_r.tick),
          .len  (pdb_len),
          .d    (pin_in[p][b]),
          .q    (pin_db[p][b])
        );
      end else begin : g_off
        assign pin_db[p][b] = 1'b0;
      end
    end
  end

  // Reset pin idles high so the filter starts released
  gpc_debounce #(
    .RST_Q (1'b1)
  ) u_rst_db (
    .mclk (mclk),
    .nrst (nrst),
    .tick (st_r.tick),
    .len  (rdb_len),
    .d    (ext_rst_n_in),
    .q    (ext_rst_n_db)
  );

  // Analog-select bits mapped onto pad positions
  always_comb begin
    ain_map        = '0;
    ain_map[0][0]  = st_r.ain_lo[0];
    ain_map[0][1]  = st_r.ain_lo[1];
    ain_map[0][7:3] = st_r.ain_lo[6:2];
    ain_map[1][0]  = st_r.ain_lo[7];
    ain_map[1][7:3] = st_r.ain_hi[4:0];
    ain_map[2][1:0] = st_r.ain_hi[6:5];
  end

  // Input path: filter or bypass, then digital receiver off for analog pins
  always_comb begin
    for (int p = 0; p < 4; p++) begin
      pin_sel[p] = (st_r.db[p] & pin_db[p]) | (~st_r.db[p] & pin_in[p]);
      dig_in[p]  = pin_sel[p] & ~ain_map[p];
      port_rd[p] = (st_r.dir[p] & st_r.data[p]) | (~st_r.dir[p] & dig_in[p]);
    end
    port_rd[2] = port_rd[2] & `GPC_PORT2_MASK;
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    case (sfr.addr)
      `GPC_A_DATA0:    rv = port_rd[0];
      `GPC_A_DATA1:    rv = port_rd[1];
      `GPC_A_DATA2:    rv = port_rd[2];
      `GPC_A_DATA3:    rv = port_rd[3];
      `GPC_A_DIR0:     rv = st_r.dir[0];
      `GPC_A_DIR1:     rv = st_r.dir[1];
      `GPC_A_DIR2:     rv = st_r.dir[2];
      `GPC_A_DIR3:     rv = st_r.dir[3];
      `GPC_A_OD0:      rv = st_r.od[0];
      `GPC_A_OD1:      rv = st_r.od[1];
      `GPC_A_OD2:      rv = st_r.od[2];
      `GPC_A_OD3:      rv = st_r.od[3];
      `GPC_A_PU0:      rv = st_r.pu[0];
      `GPC_A_PU1:      rv = st_r.pu[1];
      `GPC_A_PU2:      rv = st_r.pu[2];
      `GPC_A_PU3:      rv = st_r.pu[3];
      `GPC_A_DB0:      rv = st_r.db[0];
      `GPC_A_DB1:      rv = st_r.db[1];
      `GPC_A_DB2:      rv = st_r.db[2];
      `GPC_A_DB3:      rv = st_r.db[3];
      `GPC_A_DB_SEL:   rv = st_r.db_sel;
      `GPC_A_SINK_SEL: rv = st_r.sink_sel;
      `GPC_A_AIN_LO:   rv = st_r.ain_lo;
      `GPC_A_AIN_HI:   rv = st_r.ain_hi;
      default:         rv = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;

    // 1 us timebase shared by every filter
    st_nxt.tick = (st_r.div == TICK_LAST);
    st_nxt.div  = st_nxt.tick ? 7'd0 : st_r.div + 7'd1;

    if (sfr.wr) begin
      case (sfr.addr)
        `GPC_A_DATA0:    st_nxt.data[0] = sfr.wdata;
        `GPC_A_DATA1:    st_nxt.data[1] = sfr.wdata;
        `GPC_A_DATA2:    st_nxt.data[2] = sfr.wdata & `GPC_PORT2_MASK;
        `GPC_A_DATA3:    st_nxt.data[3] = sfr.wdata;
        `GPC_A_DIR0:     st_nxt.dir[0]  = sfr.wdata;
        `GPC_A_DIR1:     st_nxt.dir[1]  = sfr.wdata;
        `GPC_A_DIR2:     st_nxt.dir[2]  = sfr.wdata & `GPC_PORT2_MASK;
        `GPC_A_DIR3:     st_nxt.dir[3]  = sfr.wdata;
        `GPC_A_OD0:      st_nxt.od[0]   = sfr.wdata;
        `GPC_A_OD1:      st_nxt.od[1]   = sfr.wdata;
        `GPC_A_OD2:      st_nxt.od[2]   = sfr.wdata & `GPC_PORT2_MASK;
        `GPC_A_OD3:      st_nxt.od[3]   = sfr.wdata;
        `GPC_A_PU0:      st_nxt.pu[0]   = sfr.wdata;
        `GPC_A_PU1:      st_nxt.pu[1]   = sfr.wdata;
        `GPC_A_PU2:      st_nxt.pu[2]   = sfr.wdata & `GPC_PORT2_MASK;
        `GPC_A_PU3:      st_nxt.pu[3]   = sfr.wdata;
        `GPC_A_DB0:      st_nxt.db[0]   = sfr.wdata;
        `GPC_A_DB1:      st_nxt.db[1]   = sfr.wdata;
        `GPC_A_DB2:      st_nxt.db[2]   = sfr.wdata & `GPC_PORT2_MASK;
        `GPC_A_DB3:      st_nxt.db[3]   = sfr.wdata;
        `GPC_A_DB_SEL:   st_nxt.db_sel  = sfr.wdata & `GPC_DB_SEL_MASK;
        `GPC_A_SINK_SEL: st_nxt.sink_sel = sfr.wdata;
        `GPC_A_AIN_LO:   st_nxt.ain_lo  = sfr.wdata;
        `GPC_A_AIN_HI:   st_nxt.ain_hi  = sfr.wdata & `GPC_AIN_HI_MASK;
        default:         ;
      endcase
    end

    // Read data is held until the next read
    if (sfr.rd) begin
      st_nxt.rdata = rv;
    end

    // Pads follow the new register values so they change with the write.
    // Open drain only pulls low: a one releases the pin instead of driving it.
    for (int p = 0; p < 4; p++) begin
      st_nxt.pads.out[p]  = st_nxt.data[p];
      st_nxt.pads.oe_n[p] = ~(st_nxt.dir[p] & ~(st_nxt.od[p] & st_nxt.data[p]));
      st_nxt.pads.pu[p]   = st_nxt.pu[p];
    end
    st_nxt.pads.oe_n[2] = st_nxt.pads.oe_n[2] | ~`GPC_PORT2_MASK;
    st_nxt.pads.analog_input_channel        = '0;
    st_nxt.pads.analog_input_channel[0][0]  = st_nxt.ain_lo[0];
    st_nxt.pads.analog_input_channel[0][1]  = st_nxt.ain_lo[1];
    st_nxt.pads.analog_input_channel[0][7:3] = st_nxt.ain_lo[6:2];
    st_nxt.pads.analog_input_channel[1][0]  = st_nxt.ain_lo[7];
    st_nxt.pads.analog_input_channel[1][7:3] = st_nxt.ain_hi[4:0];
    st_nxt.pads.analog_input_channel[2][1:0] = st_nxt.ain_hi[6:5];
    st_nxt.sink_hi = st_nxt.sink_sel;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_r          <= '0;
      st_r.od[0]    <= `GPC_PORT0_OD_RST;
      st_r.pads.oe_n <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sfr_rdata = st_r.rdata;
  assign pads      = st_r.pads;
  assign sink_hi   = st_r.sink_hi;

endmodule : gpc_port_cfg

/* File: gpc_port_cfg_sva.sv */
`timescale 1ns/1ns
module gpc_port_cfg_chk
  import gpc_pkg::*;
#(
  parameter int TICK_CYC = 4
) (
  // Clock and reset
  input wire logic               mclk,
  input wire logic               nrst,
  // Register access
  input wire gpc_pkg::gpc_sfr_t  sfr,
  input wire logic [7:0]         sfr_rdata,
  // Pads
  input wire gpc_pkg::gpc_port_t pin_in,
  input wire gpc_pkg::gpc_pads_t pads,
  input wire logic [7:0]         sink_hi,
  // External reset
  input wire logic               ext_rst_n_in,
  input wire logic               ext_rst_n_db
);
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] wd_r;
  // Address 00 is unmapped, so it stands for no access
  assign wa = sfr.wr ? sfr.addr : 8'h00;
  assign ra = sfr.rd ? sfr.addr : 8'h00;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) wd_r <= 8'h00;
    else wd_r <= sfr.wdata;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_dir_input: assert property (wa == 8'h91 && sfr.wdata == 8'h00 |=> pads.oe_n[1] == 8'hFF)
    else $error("cleared direction left port 1 driven");
  a_data_out: assert property (wa == 8'h98 |=> pads.out[3] == wd_r)
    else $error("port 3 output does not follow data");
  a_pullup_set: assert property (wa == 8'hD9 |=> pads.pu[1] == wd_r)
    else $error("port 1 pull-up does not follow write");
  a_od_release: assert property (wa == 8'hC9 && sfr.wdata == 8'hFF |=>
    (~pads.oe_n[3] & pads.out[3]) == 8'h00)
    else $error("open-drain pin drives high");
  a_reset_state: assert property ($rose(nrst) |->
    pads.oe_n == '1 && pads.pu == '0 && sink_hi == 8'h00)
    else $error("pads not idle after reset");
  a_sink_sel: assert property (wa == 8'hDB |=> sink_hi == wd_r)
    else $error("sink select does not follow write");
  a_ain_low: assert property (wa == 8'hDC |=>
    pads.analog_input_channel[0] == {wd_r[6:2], 1'b0, wd_r[1:0]} && pads.analog_input_channel[1][0] == wd_r[7])
    else $error("low analog select mapping wrong");
  a_ain_high: assert property (wa == 8'hDD |=>
    pads.analog_input_channel[1][7:3] == wd_r[4:0] && pads.analog_input_channel[2][1:0] == wd_r[6:5])
    else $error("high analog select mapping wrong");
  a_p2_upper: assert property (wa == 8'hE1 |=> pads.pu[2][7:6] == 2'b00)
    else $error("port 2 upper pull-ups set");
  a_sel_rsvd: assert property (ra == 8'hDA |=> sfr_rdata[7:4] == 4'h0)
    else $error("selector upper bits read nonzero");
  a_rst_filter: assert property ($fell(ext_rst_n_db) |->
    !$past(ext_rst_n_in, 3) && !$past(ext_rst_n_in, 6))
    else $error("reset filter passed a short pulse");
endmodule : gpc_port_cfg_chk

bind gpc_port_cfg gpc_port_cfg_chk #(.TICK_CYC(TICK_CYC)) u_chk (
  .mclk(mclk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata), .pin_in(pin_in), .pads(pads),
  .sink_hi(sink_hi), .ext_rst_n_in(ext_rst_n_in), .ext_rst_n_db(ext_rst_n_db)
);

/* File: gpc_pad_model.sv */
`timescale 1ns/1ns
module gpc_pad_model
  import gpc_pkg::*;
(
  // Pad controls and board level
  input wire gpc_pkg::gpc_pads_t pads,
  input wire gpc_pkg::gpc_port_t ext_lvl,
  // Resolved pin level
  output     gpc_pkg::gpc_port_t pin_lvl
);
  // Board level is weak, so a pull-up wins on a released pin
  assign pin_lvl = (~pads.oe_n & pads.out) | (pads.oe_n & (pads.pu | ext_lvl));
endmodule : gpc_pad_model

/* File: tb.sv */
`timescale 1ns/1ns
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("Error %0t: got %h exp %h", $time, g, e); end end
module tb;
  import gpc_pkg::*;
  logic       mclk;
  logic       nrst;
  logic       ext_rst_n_in;
  logic       ext_rst_n_db;
  logic [7:0] sfr_rdata;
  logic [7:0] sink_hi;
  gpc_sfr_t   sfr;
  gpc_port_t  pin_in;
  gpc_port_t  ext_lvl;
  gpc_pads_t  pads;
  int         failures;
  int         n_compared;
  logic [7:0] cfg [20] = '{8'h89, 8'h91, 8'h99, 8'hA1, 8'hB1, 8'hB9, 8'hC1, 8'hC9, 8'hD1, 8'hD9,
                           8'hE1, 8'hE9, 8'hE2, 8'hE3, 8'hE4, 8'hE5, 8'hDA, 8'hDB, 8'hDC, 8'hDD};
  gpc_port_cfg #(.TICK_CYC(4)) dut (.mclk(mclk), .nrst(nrst), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .pin_in(pin_in), .pads(pads), .sink_hi(sink_hi), .ext_rst_n_in(ext_rst_n_in), .ext_rst_n_db(ext_rst_n_db));
  gpc_pad_model pm (.pads(pads), .ext_lvl(ext_lvl), .pin_lvl(pin_in));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  function automatic logic [7:0] msk(input logic [7:0] a);
    return (a == 8'h99 || a == 8'hC1 || a == 8'hE1 || a == 8'hE4) ? 8'h3F :
           a == 8'hDA ? 8'h0F : a == 8'hDD ? 8'h7F : 8'hFF;
  endfunction : msk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    sfr = '{1'b1, 1'b0, a, d};
    @(negedge mclk);
    sfr.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge mclk);
    sfr = '{1'b0, 1'b1, a, 8'h00};
    @(negedge mclk);
    sfr.rd = 1'b0;
    `CHK(sfr_rdata, e)
  endtask : rd
  task automatic give_verdict;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  initial begin
    #100000;
    failures++;
    give_verdict();
  end
  initial begin
    nrst = 1'b0;
    sfr = '0;
    ext_lvl = '0;
    ext_rst_n_in = 1'b1;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    foreach (cfg[i]) rd(cfg[i], i == 4 ? 8'h04 : 8'h00);
    foreach (cfg[i]) wr(cfg[i], 8'hFF);
    foreach (cfg[i]) rd(cfg[i], msk(cfg[i]));
    foreach (cfg[i]) wr(cfg[i], 8'h00);
    rd(8'h81, 8'h00);
    // Port 3 drives, then releases its ones, then pulls them up
    wr(8'hA1, 8'hFF);
    wr(8'h98, 8'hA5);
    rd(8'h98, 8'hA5);
    `CHK(pin_in[3], 8'hA5)
    wr(8'hC9, 8'hFF);
    `CHK(pin_in[3], 8'h00)
    wr(8'hE9, 8'hFF);
    `CHK(pin_in[3], 8'hA5)
    wr(8'hDB, 8'h3C);
    `CHK(sink_hi, 8'h3C)
    // Analog pins read zero on the digital path
    ext_lvl = '1;
    wr(8'hDC, 8'hFF);
    wr(8'hDD, 8'h7F);
    rd(8'h80, 8'h04);
    rd(8'h88, 8'h06);
    rd(8'h90, 8'h3C);
    wr(8'hDC, 8'h00);
    wr(8'hDD, 8'h00);
    // Port filter, 1 us then 8 us
    ext_lvl[1] = 8'h00;
    wr(8'hE3, 8'h01);
    repeat (40) @(negedge mclk);
    ext_lvl[1][0] = 1'b1;
    repeat (2) @(negedge mclk);
    ext_lvl[1][0] = 1'b0;
    repeat (20) @(negedge mclk);
    rd(8'h88, 8'h00);
    ext_lvl[1][0] = 1'b1;
    rd(8'h88, 8'h00);
    repeat (12) @(negedge mclk);
    rd(8'h88, 8'h01);
    wr(8'hDA, 8'h03);
    ext_lvl[1][0] = 1'b0;
    repeat (20) @(negedge mclk);
    rd(8'h88, 8'h01);
    repeat (30) @(negedge mclk);
    rd(8'h88, 8'h00);
    ext_lvl[1][0] = 1'b1;
    rd(8'h88, 8'h00);
    wr(8'hE3, 8'h00);
    rd(8'h88, 8'h01);
    // Reset pin filter, 8 us then 64 us
    ext_rst_n_in = 1'b0;
    repeat (20) @(negedge mclk);
    `CHK(ext_rst_n_db, 1'b1)
    repeat (30) @(negedge mclk);
    `CHK(ext_rst_n_db, 1'b0)
    wr(8'hDA, 8'h0C);
    ext_rst_n_in = 1'b1;
    repeat (200) @(negedge mclk);
    `CHK(ext_rst_n_db, 1'b0)
    repeat (100) @(negedge mclk);
    `CHK(ext_rst_n_db, 1'b1)
    give_verdict();
  end
endmodule : tb
